// File: uhs_host.sv
/*
 Host side of the request/acknowledge handshake on a two-wire serial
 link: a parameterised word FIFO and the top module uhs_host.
 Assumes rx_in is already synchronous to clk_in and idles high.
*/
`timescale 1ns/1ps

// ==========================================================
// Word FIFO with registered flags
module uhs_fifo #(
   parameter int unsigned W = 9,
   parameter int unsigned D = 8
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   // Fill side
   input  wire logic         in_valid_in,
   input  wire logic [W-1:0] in_data_in,
   output logic              in_ready_out,
   // Drain side
   output logic              out_valid_out,
   output logic [W-1:0]      out_data_out,
   input  wire logic         out_ready_in
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   localparam int unsigned CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [CW-1:0]       cnt;
      logic                in_rdy;
      logic                out_vld;
   } uhs_fifo_st_t;

   uhs_fifo_st_t s;
   uhs_fifo_st_t next_s;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      logic push;
      logic pop;
      push   = in_valid_in && s.in_rdy;
      pop    = out_ready_in && s.out_vld;
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data_in;
         next_s.wr        = bump(s.wr);
      end
      if (pop) begin
         next_s.rd = bump(s.rd);
      end
      if (push && !pop) begin
         next_s.cnt = CW'(s.cnt + 1'b1);
      end else if (pop && !push) begin
         next_s.cnt = CW'(s.cnt - 1'b1);
      end
      next_s.in_rdy  = next_s.cnt != CW'(D);
      next_s.out_vld = next_s.cnt != '0;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s        <= '0;
         s.in_rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign in_ready_out  = s.in_rdy;
   assign out_valid_out = s.out_vld;
   assign out_data_out  = s.mem[s.rd];
endmodule

// ==========================================================
// Host handshake controller
module uhs_host #(
   parameter int unsigned ACK_TMO_CYC = uhs_pkg::ACK_TMO_CYC
) (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   // Serial link
   output logic                    tx_out,
   input  wire logic               rx_in,
   // Outgoing packet bytes
   input  wire logic               pkt_valid_in,
   input  wire uhs_pkg::uhs_word_t pkt_word_in,
   output logic                    pkt_ready_out,
   // Reception for the upper layer
   input  wire logic               rx_arm_in,
   input  wire logic [7:0]         rx_len_in,
   output uhs_pkg::uhs_rx_t        rx_out,
   // Status
   output uhs_pkg::uhs_state_t     state_out,
   output logic                    tmo_flag_out,
   input  wire logic               tmo_clr_in
);
   import uhs_pkg::*;

   localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(ACK_TMO_CYC - 1);

   typedef struct packed {
      uhs_state_t       st;
      logic             tx_line;
      logic             tx_busy;
      logic [8:0]       tx_sh;
      logic [3:0]       tx_bits;
      logic [8:0]       tx_cyc;
      logic             tx_last;
      logic [TMO_W-1:0] tmo;
      logic             tmo_flag;
      logic             rx_pkt;
      logic             rx_busy;
      logic [7:0]       rx_sh;
      logic [3:0]       rx_bits;
      logic [8:0]       rx_cyc;
      logic [7:0]       rx_left;
      uhs_rx_t          rx;
      logic             pop;
   } uhs_host_st_t;

   uhs_host_st_t s;
   uhs_host_st_t next_s;
   logic         fifo_vld;
   uhs_word_t    fifo_word;

   // Data bits plus stop bit; the start bit goes out at load time
   function automatic logic [8:0] tx_frame(input logic [7:0] b);
      tx_frame = {LINE_IDLE, b};
   endfunction

   uhs_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk_in        (clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (pkt_valid_in),
      .in_data_in    (pkt_word_in),
      .in_ready_out  (pkt_ready_out),
      .out_valid_out (fifo_vld),
      .out_data_out  (fifo_word),
      .out_ready_in  (s.pop)
   );

   // ==========================================================
   // Next state
   logic tx_end;
   logic rx_byte;
   logic is_ack;

   always_comb begin
      next_s          = s;
      next_s.rx.valid = 1'b0;
      next_s.rx.done  = 1'b0;
      next_s.pop      = 1'b0;
      tx_end  = s.tx_busy && s.tx_cyc == BIT_LAST && s.tx_bits == FRAME_LAST;
      rx_byte = 1'b0;

      // Transmit shifter
      if (s.tx_busy) begin
         if (s.tx_cyc == BIT_LAST) begin
            next_s.tx_cyc = '0;
            if (s.tx_bits == FRAME_LAST) begin
               next_s.tx_busy = 1'b0;
            end else begin
               next_s.tx_bits = 4'(s.tx_bits + 1'b1);
               next_s.tx_line = s.tx_sh[0];
               next_s.tx_sh   = {LINE_IDLE, s.tx_sh[8:1]};
            end
         end else begin
            next_s.tx_cyc = 9'(s.tx_cyc + 1'b1);
         end
      end

      // Receive shifter, sampled mid-bit
      if (!s.rx_busy) begin
         if (!rx_in) begin
            next_s.rx_busy = 1'b1;
            next_s.rx_cyc  = BIT_HALF;
            next_s.rx_bits = '0;
         end
      end else if (s.rx_cyc == BIT_LAST) begin
         next_s.rx_cyc  = '0;
         next_s.rx_bits = 4'(s.rx_bits + 1'b1);
         if (s.rx_bits == '0) begin
            next_s.rx_busy = !rx_in;
         end else if (s.rx_bits == FRAME_LAST) begin
            next_s.rx_busy = 1'b0;
            rx_byte        = rx_in;
         end else begin
            next_s.rx_sh = {rx_in, s.rx_sh[7:1]};
         end
      end else begin
         next_s.rx_cyc = 9'(s.rx_cyc + 1'b1);
      end
      is_ack = rx_byte && s.rx_sh == ACK_BYTE && s.st == TX_AWAIT_ACK;

      // Byte collection for the upper layer
      if (rx_byte && !is_ack && s.rx_left != '0) begin
         next_s.rx.valid = 1'b1;
         next_s.rx.data  = s.rx_sh;
         next_s.rx_left  = 8'(s.rx_left - 1'b1);
         next_s.rx.done  = s.rx_left == 8'h01;
      end
      if (rx_arm_in) begin
         next_s.rx_left = rx_len_in;
      end

      // Sticky timeout flag, a new timeout beats a clear
      if (tmo_clr_in) begin
         next_s.tmo_flag = 1'b0;
      end

      // Handshake driver; reception feeds it the acknowledge cue and any other byte received while a request is pending as a packet-as-acknowledge cue
      unique case (s.st)
         TX_IDLE: begin
            if (fifo_vld && !s.tx_busy) begin
               next_s.st      = TX_SENDING_REQUEST;
               next_s.tx_busy = 1'b1;
               next_s.tx_line = 1'b0;
               next_s.tx_sh   = tx_frame(REQ_BYTE);
               next_s.tx_bits = '0;
               next_s.tx_cyc  = '0;
               next_s.rx_pkt  = 1'b0;
            end
         end
         TX_SENDING_REQUEST: begin
            if (rx_byte) begin
               next_s.rx_pkt = 1'b1;
            end
            if (tx_end) begin
               next_s.tmo = '0;
               next_s.st  = (s.rx_pkt || rx_byte) ? TX_PACKET_AS_ACK
                                                  : TX_AWAIT_ACK;
            end
         end
         TX_AWAIT_ACK: begin
            if (is_ack) begin
               next_s.st = TX_ACTIVE;
            end else if (rx_byte) begin
               next_s.st = TX_PACKET_AS_ACK;
            end else if (s.tmo == TMO_LAST) begin
               next_s.st       = TX_SENDING_REQUEST;
               next_s.tmo_flag = 1'b1;
               next_s.tx_busy  = 1'b1;
               next_s.tx_line  = 1'b0;
               next_s.tx_sh    = tx_frame(REQ_BYTE);
               next_s.tx_bits  = '0;
               next_s.tx_cyc   = '0;
               next_s.rx_pkt   = 1'b0;
            end else begin
               next_s.tmo = TMO_W'(s.tmo + 1'b1);
            end
         end
         TX_PACKET_AS_ACK: begin
            next_s.st = TX_ACTIVE;
         end
         TX_ACTIVE: begin
            if (tx_end && s.tx_last) begin
               next_s.st = TX_IDLE;
            end else if (!s.tx_busy && !s.pop && fifo_vld) begin
               next_s.pop     = 1'b1;
               next_s.tx_busy = 1'b1;
               next_s.tx_line = 1'b0;
               next_s.tx_sh   = tx_frame(fifo_word.data);
               next_s.tx_bits = '0;
               next_s.tx_cyc  = '0;
               next_s.tx_last = fifo_word.last;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s         <= '0;
         s.tx_line <= LINE_IDLE;
         s.tx_sh   <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign tx_out       = s.tx_line;
   assign rx_out       = s.rx;
   assign state_out    = s.st;
   assign tmo_flag_out = s.tmo_flag;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_req_done;
      s.st == TX_SENDING_REQUEST && tx_end && !s.rx_pkt && !rx_byte;
   endsequence
   sequence s_ack_in;
      s.st == TX_AWAIT_ACK && is_ack;
   endsequence
   sequence s_timeout;
      s.st == TX_AWAIT_ACK && !rx_byte && s.tmo == TMO_LAST;
   endsequence

   chk_req_byte_out: assert property (
      (s.st == TX_SENDING_REQUEST && $past(s.st) != TX_SENDING_REQUEST)
      |-> s.tx_sh == tx_frame(REQ_BYTE) && !s.tx_line)
      else $error("request byte not loaded on handshake start");
   chk_active_entry: assert property (
      (s.st == TX_ACTIVE && $past(s.st) != TX_ACTIVE)
      |-> $past(s.st) inside {TX_AWAIT_ACK, TX_PACKET_AS_ACK})
      else $error("packet started without a request");
   chk_req_shifting: assert property (
      s.st == TX_SENDING_REQUEST |-> s.tx_busy)
      else $error("request state without request shifting");
   chk_await_start: assert property (
      s_req_done |=> s.st == TX_AWAIT_ACK && s.tmo == '0 ##1 s.tmo == 1)
      else $error("timer or wait state wrong after request");
   chk_packet_ack: assert property (
      (s.st == TX_AWAIT_ACK && rx_byte && !is_ack)
      |=> s.st == TX_PACKET_AS_ACK ##1 s.st == TX_ACTIVE)
      else $error("incoming packet not taken as acknowledge");
   chk_ack_send: assert property (
      s_ack_in ##1 fifo_vld |=> s.tx_busy && s.st == TX_ACTIVE)
      else $error("packet not sent after acknowledge");
   chk_timeout_retry: assert property (
      s_timeout |=> s.st == TX_SENDING_REQUEST && s.tmo_flag && !s.tx_line)
      else $error("timeout did not resend request");
   chk_done_idle: assert property (
      (s.st == TX_ACTIVE && tx_end && s.tx_last)
      |=> s.st == TX_IDLE ##1 (s.st == TX_IDLE || s.st == TX_SENDING_REQUEST))
      else $error("driver not idle after packet");
   // A re-arm in the done cycle reloads the count, so the count need not be zero then
   chk_rx_count: assert property (
      s.rx.done |-> s.rx.valid && (s.rx_left == '0 || $past(rx_arm_in)))
      else $error("receive count done mismatch");
   chk_rx_no_state: assert property (
      (s.st == TX_IDLE && rx_byte && !fifo_vld) |=> s.st == TX_IDLE)
      else $error("reception moved the idle driver");
endmodule

// File: uhs_pkg.sv
/*
 Shared constants and carrier types for the host-side request handshake
 controller of a two-wire serial link to a radio module.
 Assumes a 40 MHz system clock and 8N1 framing at a fixed baud rate.
*/
package uhs_pkg;
   // ==========================================================
   // Handshake bytes
   localparam logic [7:0] REQ_BYTE  = 8'hC0;
   localparam logic [7:0] ACK_BYTE  = 8'h88;
   localparam logic       LINE_IDLE = 1'h1;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned BAUD       = 115_200;
   localparam int unsigned BIT_CYC    = CLK_HZ / BAUD;
   localparam int unsigned BIT_W      = 9;
   localparam logic [8:0]  BIT_LAST   = 9'(BIT_CYC - 1);
   localparam logic [8:0]  BIT_HALF   = 9'(BIT_CYC / 2);
   localparam logic [3:0]  FRAME_LAST = 4'h9;
   localparam int unsigned ACK_TMO_US  = 10_000;
   localparam int unsigned ACK_TMO_CYC = ACK_TMO_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TMO_W       = 20;

   // ==========================================================
   // Buffer shape
   localparam int unsigned FIFO_W = 9;
   localparam int unsigned FIFO_D = 8;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_SENDING_REQUEST,
      TX_AWAIT_ACK,
      TX_PACKET_AS_ACK,
      TX_ACTIVE
   } uhs_state_t;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } uhs_word_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       done;
   } uhs_rx_t;
endpackage

// File: uhs_radio_model.sv
/*
 Behavioural radio module on the far end of the serial link.
 Assumes uhs_pkg timing, 8N1 framing and a host line that idles high.
*/
`timescale 1ns/1ps
module uhs_radio_model
   import uhs_pkg::*;
(
   // Clock
   input  wire logic clk_in,
   // Link
   input  wire logic line_in,
   output logic      line_out,
   // Control
   input  wire logic silent_in
);
   logic       busy;
   logic [7:0] got_q[$];
   logic [7:0] b;

   initial begin
      line_out = LINE_IDLE;
      busy     = 1'b0;
   end

   // ====
   // Sender, LSB first; busy stands for the whole frame
   task automatic send_byte(input logic [7:0] d);
      logic [9:0] f;
      f    = {1'b1, d, 1'b0};
      busy = 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_in);
         #1;
         line_out = f[i];
         repeat (BIT_CYC - 1) @(posedge clk_in);
      end
      @(posedge clk_in);
      #1;
      busy = 1'b0;
   endtask

   // ====
   // Receiver sampling mid-bit; a request is acknowledged only when idle
   initial forever begin
      @(negedge line_in);
      repeat (BIT_HALF) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_in);
         b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      got_q.push_back(b);
      if (b == REQ_BYTE && !busy && !silent_in) begin
         fork
            send_byte(ACK_BYTE);
         join_none
      end
   end
endmodule

// File: test_uhs_host.sv
/*
 Self-checking bench for uhs_host with the radio model on its link.
 Assumes uhs_pkg, the design files and uhs_radio_model compile first.
*/
`timescale 1ns/1ps
module test_uhs_host;
   import uhs_pkg::*;
   localparam int unsigned TMO = 5000;
   logic       clk_in;
   logic       arst_n_in;
   logic       tx_out;
   logic       rx_in;
   logic       pkt_valid_in;
   uhs_word_t  pkt_word_in;
   logic       pkt_ready_out;
   logic       rx_arm_in;
   logic [7:0] rx_len_in;
   uhs_rx_t    rx_out;
   uhs_state_t state_out;
   logic       tmo_flag_out;
   logic       tmo_clr_in;
   logic       silent;
   int         err_count;
   int         num_checks;
   int         done_n;
   logic [7:0] st_q[$];
   logic [7:0] rx_q[$];

   uhs_host #(.ACK_TMO_CYC(TMO)) dut (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .tx_out(tx_out), .rx_in(rx_in),
      .pkt_valid_in(pkt_valid_in), .pkt_word_in(pkt_word_in),
      .pkt_ready_out(pkt_ready_out), .rx_arm_in(rx_arm_in), .rx_len_in(rx_len_in),
      .rx_out(rx_out), .state_out(state_out), .tmo_flag_out(tmo_flag_out),
      .tmo_clr_in(tmo_clr_in));
   uhs_radio_model model (.clk_in(clk_in), .line_in(tx_out), .line_out(rx_in),
      .silent_in(silent));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // ====
   // Monitors
   always @(state_out) st_q.push_back(8'(state_out));
   always @(posedge clk_in) begin
      #1;
      if (rx_out.valid === 1'b1) rx_q.push_back(rx_out.data);
      if (rx_out.done === 1'b1) done_n++;
   end

   // ====
   // Helpers
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s: expected %0h, seen %0h", n, e, g);
      end
   endtask

   task chk_seq(input string n, input logic [7:0] e[$], input logic [7:0] g[$]);
      chk({n, " count"}, e.size(), g.size());
      foreach (e[i]) chk(n, e[i], g[i]);
   endtask

   task tick;
      @(posedge clk_in);
      #1;
   endtask

   task wait_st(input uhs_state_t s, output int n);
      n = 0;
      while (state_out !== s && n < 60000) begin
         tick;
         n++;
      end
      chk("state reached", s, state_out);
   endtask

   task push(input logic [7:0] d, input logic l);
      int n;
      tick;
      pkt_valid_in = 1'b1;
      pkt_word_in  = '{last: l, data: d};
      for (n = 0; n < 99 && pkt_ready_out !== 1'b1; n++) tick;
      tick;
      pkt_valid_in = 1'b0;
   endtask

   task arm(input logic [7:0] len);
      tick;
      rx_arm_in = 1'b1;
      rx_len_in = len;
      tick;
      rx_arm_in = 1'b0;
   endtask

   task clr;
      st_q        = {};
      rx_q        = {};
      model.got_q = {};
      done_n      = 0;
   endtask

   // ====
   // Scenarios
   task t_reset;
      chk("state", TX_IDLE, state_out);
      chk("tx idle", 1, tx_out);
      chk("ready", 1, pkt_ready_out);
      chk("flag", 0, tmo_flag_out);
      chk("rx", 0, rx_out);
   endtask

   task t_ack;
      int n;
      clr;
      arm(8'h01);
      push(8'hA5, 1'b0);
      push(8'h3C, 1'b1);
      wait_st(TX_SENDING_REQUEST, n);
      wait_st(TX_IDLE, n);
      chk_seq("states", {8'h01, 8'h02, 8'h04, 8'h00}, st_q);
      chk_seq("link", {REQ_BYTE, 8'hA5, 8'h3C}, model.got_q);
      chk("ack kept", 0, rx_q.size());
   endtask

   task t_pkt_ack;
      int n;
      clr;
      arm(8'h01);
      push(8'h42, 1'b1);
      wait_st(TX_SENDING_REQUEST, n);
      model.send_byte(8'h11);
      wait_st(TX_IDLE, n);
      chk_seq("states", {8'h01, 8'h03, 8'h04, 8'h00}, st_q);
      chk_seq("link", {REQ_BYTE, 8'h42}, model.got_q);
      chk_seq("rx", {8'h11}, rx_q);
      chk("done", 1, done_n);
   endtask

   // Module stays silent, then sends a packet byte while the host awaits the ack
   task t_late_pkt;
      int n;
      clr;
      arm(8'h01);
      silent = 1'b1;
      push(8'h43, 1'b1);
      wait_st(TX_AWAIT_ACK, n);
      model.send_byte(8'h12);
      silent = 1'b0;
      wait_st(TX_IDLE, n);
      chk_seq("states", {8'h01, 8'h02, 8'h03, 8'h04, 8'h00}, st_q);
      chk_seq("link", {REQ_BYTE, 8'h43}, model.got_q);
      chk_seq("rx", {8'h12}, rx_q);
      chk("done", 1, done_n);
   endtask

   task t_recv;
      clr;
      arm(8'h02);
      model.send_byte(8'h5A);
      model.send_byte(ACK_BYTE);
      model.send_byte(8'h77);
      chk_seq("rx", {8'h5A, ACK_BYTE}, rx_q);
      chk("done", 1, done_n);
      chk("no moves", 0, st_q.size());
   endtask

   task t_tmo;
      int n;
      logic [7:0] e[$];
      clr;
      silent = 1'b1;
      for (int i = 0; i < 8; i++) push(8'hD0 + 8'(i), i == 7);
      tick;
      tick;
      chk("full", 0, pkt_ready_out);
      wait_st(TX_AWAIT_ACK, n);
      wait_st(TX_SENDING_REQUEST, n);
      chk("span", 1, n >= TMO - 2 && n <= TMO + 1);
      chk("flag", 1, tmo_flag_out);
      silent     = 1'b0;
      tmo_clr_in = 1'b1;
      tick;
      tmo_clr_in = 1'b0;
      tick;
      chk("flag clear", 0, tmo_flag_out);
      wait_st(TX_IDLE, n);
      e = {REQ_BYTE, REQ_BYTE};
      for (int i = 0; i < 8; i++) e.push_back(8'hD0 + 8'(i));
      chk_seq("states", {8'h01, 8'h02, 8'h01, 8'h02, 8'h04, 8'h00}, st_q);
      chk_seq("link", e, model.got_q);
      chk("ready", 1, pkt_ready_out);
   endtask

   // ====
   // Closing
   task conclude;
      $display("checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (95000) @(posedge clk_in);
      err_count++;
      conclude;
   end

   initial begin
      arst_n_in    = 1'b0;
      pkt_valid_in = 1'b0;
      pkt_word_in  = '0;
      rx_arm_in    = 1'b0;
      rx_len_in    = 8'h00;
      tmo_clr_in   = 1'b0;
      silent       = 1'b0;
      err_count    = 0;
      num_checks   = 0;
      done_n       = 0;
      repeat (4) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      t_reset;
      t_ack;
      t_pkt_ack;
      t_late_pkt;
      t_recv;
      t_tmo;
      conclude;
   end
endmodule
